// ==== poe_map.svh ====
`ifndef POE_MAP_SVH
`define POE_MAP_SVH
// Functional notes
// - Power on drives the gate pull-up; power off drives the gate pull-down.
// - Fault counter counts up each tick while current is above cut threshold.
// - Fault counter also counts up while output is above power-good level.
// - Full count removes power at once and latches the overcurrent fault bit (the start-up fault bit during start-up).
// - Overcurrent timeout comes from timing register bits 3:2.
// - Without overcurrent the counter counts down at one sixteenth rate.
// - Counter stops at zero and never wraps.
// - After expiry counting down continues; no repower until count is zero.
// - Manual and semiauto power-on requests are ignored while count is nonzero.
// - Auto mode repowers only on a good detection after count reaches zero.
// - Every power-up sequence starts the start-up timer.
// - Start-up timeout replaces cut timeout during start-up; counter still runs.
// - Disconnect timer is held idle until the start-up timer has expired.
// - Limit held for whole start-up interval records start-up fault, powers off.
// - Start-up duration comes from timing register bits 5:4.
// - No fault at start-up end below cut; then disconnect timeout applies.
// - Foldback limit counts as current limit and keeps the counter counting.
// - Short trip forces pull-down, then releases after about 100 us.
// - Power-off bit removes port power in any mode.
// - Shutdown mode clears the port's fault, status and enable bits.

`define NPORTS      4
`define CNT_W       12
`define CLK_MHZ     50
`define TICK_US     100
`define SHORT_US    100
`define DOWN_DIV    4'hf

`define REG_FAULT     8'h06
`define REG_FAULT_CLR 8'h07
`define REG_STATUS    8'h10
`define REG_RUN       8'h11
`define REG_MODE      8'h12
`define REG_DC_EN     8'h13
`define REG_TIMING    8'h16
`define REG_PWR_PB    8'h19

`define TDIS_POS    0
`define TICUT_POS   2
`define TSTART_POS  4

`define RST_MODE    8'hff
`define RST_DC_EN   8'h0f
`define RST_TIMING  8'h00

`define ICUT_TAB  {12'd2400, 12'd1200, 12'd300, 12'd600}
`define START_TAB {12'd1200, 12'd300, 12'd1200, 12'd600}
`define TDIS_TAB  {12'd3000, 12'd1500, 12'd750, 12'd3000}
`endif

// ==== poe_pkg.sv ====
package poe_pkg;
  typedef enum logic [1:0] {
    mode_shutdown,
    mode_manual,
    mode_semi,
    mode_auto
  } port_mode_e;

  typedef enum logic [1:0] {
    ps_off,
    ps_start,
    ps_on
  } pwr_state_e;
endpackage : poe_pkg

// ==== poe_port_overcurrent_timers.sv ====
`timescale 1ns/1ps
`include "poe_map.svh"
module poe_port_overcurrent_timers
  import poe_pkg::*;
#(
  parameter int TICK_CYC  = `TICK_US * `CLK_MHZ,
  parameter int SHORT_CYC = `SHORT_US * `CLK_MHZ
) (
  // Clock, reset and enable
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  ce_in,
  // Register port
  input  wire logic [7:0]            addr_in,
  input  wire logic [7:0]            wr_data_in,
  input  wire logic                  wr_en_in,
  input  wire logic                  rd_en_in,
  output logic      [7:0]            rd_data_out,
  // Sense comparators and detection
  input  wire logic [`NPORTS-1:0]    cut_sense_in,
  input  wire logic [`NPORTS-1:0]    power_good_in,
  input  wire logic [`NPORTS-1:0]    hard_current_limit_in,
  input  wire logic [`NPORTS-1:0]    short_trip_in,
  input  wire logic [`NPORTS-1:0]    undercurrent_in,
  input  wire logic [`NPORTS-1:0]    detect_good_in,
  // Gate drive
  output logic      [`NPORTS-1:0]    gate_pullup_out,
  output logic      [`NPORTS-1:0]    gate_pulldown_out
);
  localparam int N  = `NPORTS;
  localparam int CW = `CNT_W;

  typedef struct packed {
    pwr_state_e [N-1:0]         st;
    logic       [N-1:0][CW-1:0] cnt;
    logic       [N-1:0][CW-1:0] stmr;
    logic       [N-1:0][CW-1:0] dtmr;
    logic       [N-1:0][15:0]   sc;
    logic       [N-1:0]         all_lim;
    logic       [N-1:0]         up;
    logic       [N-1:0]         dn;
    logic       [N-1:0]         fault_oc;
    logic       [N-1:0]         fault_st;
    logic       [N-1:0]         fault_dis;
    logic       [7:0]           mode;
    logic       [7:0]           dc_en;
    logic       [7:0]           timing;
    logic       [15:0]          pre;
    logic       [3:0]           div;
    logic       [7:0]           rdata;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  function automatic logic [CW-1:0] pick(input logic [1:0]    sel,
                                         input logic [4*CW-1:0] tab);
    pick = tab[sel*CW +: CW];
  endfunction : pick

  logic          tick;
  logic          dn_tick;
  logic [CW-1:0] full_icut;
  logic [CW-1:0] full_start;
  logic [CW-1:0] full_dis;

  // One timebase feeds both rates so the 16:1 off/on ratio is exact.
  assign tick       = (s_r.pre == 16'(TICK_CYC - 1));
  assign dn_tick    = tick && (s_r.div == `DOWN_DIV);
  assign full_icut  = pick(s_r.timing[`TICUT_POS +: 2], `ICUT_TAB);
  assign full_start = pick(s_r.timing[`TSTART_POS +: 2], `START_TAB);
  assign full_dis   = pick(s_r.timing[`TDIS_POS +: 2], `TDIS_TAB);

  always_comb begin
    logic          over;
    logic          run;
    logic          req_on;
    logic          req_off;
    logic [CW-1:0] full;
    port_mode_e    md;
    over    = 1'b0;
    run     = 1'b0;
    req_on  = 1'b0;
    req_off = 1'b0;
    full    = '0;
    md      = mode_shutdown;
    s_nxt   = s_r;
    s_nxt.rdata = 8'h00;

    s_nxt.pre = tick ? 16'h0000 : s_r.pre + 16'h0001;
    if (tick) begin
      s_nxt.div = s_r.div + 4'h1;
    end

    // Clears act first so a fault raised in the same cycle survives.
    if (rd_en_in && addr_in == `REG_FAULT_CLR) begin
      s_nxt.fault_oc = '0;
      s_nxt.fault_st = '0;
    end
    if (wr_en_in) begin
      unique case (addr_in)
        `REG_MODE:   s_nxt.mode   = wr_data_in;
        `REG_DC_EN:  s_nxt.dc_en  = wr_data_in;
        `REG_TIMING: s_nxt.timing = wr_data_in;
        `REG_STATUS: s_nxt.fault_dis = s_r.fault_dis & ~wr_data_in[7:4];
        default: ;
      endcase
    end

    for (int i = 0; i < N; i++) begin
      md      = port_mode_e'(s_r.mode[2*i +: 2]);
      run     = (s_r.st[i] != ps_off);
      over    = cut_sense_in[i] | power_good_in[i]
              | hard_current_limit_in[i];
      req_off = wr_en_in && addr_in == `REG_PWR_PB && wr_data_in[4+i];
      req_on  = 1'b0;
      if (md == mode_manual || md == mode_semi) begin
        req_on = wr_en_in && addr_in == `REG_PWR_PB && wr_data_in[i];
      end else if (md == mode_auto) begin
        req_on = detect_good_in[i];
      end
      full = (s_r.st[i] == ps_start) ? full_start : full_icut;

      // Up/down duty-cycle counter; it keeps running after power is off.
      if (tick && run && over) begin
        if (s_r.cnt[i] != full) begin
          s_nxt.cnt[i] = s_r.cnt[i] + 12'd1;
        end
      end else if (dn_tick && s_r.cnt[i] != '0) begin
        s_nxt.cnt[i] = s_r.cnt[i] - 12'd1;
      end

      if (s_r.sc[i] != 16'h0000) begin
        s_nxt.sc[i] = s_r.sc[i] - 16'h0001;
      end
      if (run && short_trip_in[i]) begin
        s_nxt.sc[i] = 16'(SHORT_CYC);
      end

      unique case (s_r.st[i])
        ps_off: begin
          // Repower is only taken from an idle, fully cooled counter.
          if (req_on && !req_off && s_r.cnt[i] == '0) begin
            s_nxt.st[i]      = ps_start;
            s_nxt.stmr[i]    = '0;
            s_nxt.all_lim[i] = 1'b1;
            s_nxt.dtmr[i]    = '0;
          end
        end
        ps_start: begin
          s_nxt.dtmr[i] = '0;
          if (tick) begin
            s_nxt.stmr[i] = s_r.stmr[i] + 12'd1;
            s_nxt.all_lim[i] = s_r.all_lim[i]
                             & hard_current_limit_in[i];
          end
          if (s_nxt.cnt[i] == full) begin
            s_nxt.st[i]       = ps_off;
            s_nxt.fault_st[i] = 1'b1;
          end else if (tick && s_nxt.stmr[i] == full_start) begin
            if (s_nxt.all_lim[i]) begin
              s_nxt.st[i]       = ps_off;
              s_nxt.fault_st[i] = 1'b1;
            end else begin
              s_nxt.st[i] = ps_on;
            end
          end
        end
        ps_on: begin
          if (s_nxt.cnt[i] == full) begin
            s_nxt.st[i]       = ps_off;
            s_nxt.fault_oc[i] = 1'b1;
          end else if (s_r.dc_en[i] && undercurrent_in[i]) begin
            if (tick) begin
              s_nxt.dtmr[i] = s_r.dtmr[i] + 12'd1;
            end
            if (s_nxt.dtmr[i] == full_dis) begin
              s_nxt.st[i]        = ps_off;
              s_nxt.fault_dis[i] = 1'b1;
            end
          end else begin
            s_nxt.dtmr[i] = '0;
          end
        end
        default: s_nxt.st[i] = ps_off;
      endcase

      if (req_off) begin
        s_nxt.st[i] = ps_off;
      end
      if (md == mode_shutdown) begin
        s_nxt.st[i]        = ps_off;
        s_nxt.fault_oc[i]  = 1'b0;
        s_nxt.fault_st[i]  = 1'b0;
        s_nxt.fault_dis[i] = 1'b0;
        s_nxt.dc_en[i]     = 1'b0;
      end
      if (s_nxt.st[i] == ps_off) begin
        s_nxt.sc[i] = 16'h0000;
      end

      // The short timer overrides the pull-up while it runs.
      s_nxt.up[i] = (s_nxt.st[i] != ps_off)
                  && (s_nxt.sc[i] == 16'h0000);
      s_nxt.dn[i] = !s_nxt.up[i];
    end

    if (rd_en_in) begin
      unique case (addr_in)
        `REG_FAULT, `REG_FAULT_CLR: s_nxt.rdata = {s_r.fault_st,
                                                   s_r.fault_oc};
        `REG_STATUS: begin
          for (int i = 0; i < N; i++) begin
            s_nxt.rdata[i] = (s_r.st[i] != ps_off);
          end
          s_nxt.rdata[7:4] = s_r.fault_dis;
        end
        `REG_RUN: begin
          for (int i = 0; i < N; i++) begin
            s_nxt.rdata[i]   = (s_r.cnt[i] != '0);
            s_nxt.rdata[4+i] = (s_r.st[i] == ps_start);
          end
        end
        `REG_MODE:   s_nxt.rdata = s_r.mode;
        `REG_DC_EN:  s_nxt.rdata = s_r.dc_en;
        `REG_TIMING: s_nxt.rdata = s_r.timing;
        default:     s_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r        <= '0;
      s_r.dn     <= '1;
      s_r.mode   <= `RST_MODE;
      s_r.dc_en  <= `RST_DC_EN;
      s_r.timing <= `RST_TIMING;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  assign rd_data_out       = s_r.rdata;
  assign gate_pullup_out   = s_r.up;
  assign gate_pulldown_out = s_r.dn;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  property p_gate_exclusive;
    gate_pullup_out[0] |-> !gate_pulldown_out[0] && s_r.st[0] != ps_off;
  endproperty
  a_gate_exclusive: assert property (p_gate_exclusive)
    else $error("Pull-up active with port off or pull-down on.");

  property p_count_up;
    ce_in && tick && cut_sense_in[0] && s_r.st[0] == ps_on
      && s_r.cnt[0] != full_icut
      |=> s_r.cnt[0] == $past(s_r.cnt[0]) + 12'd1;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("Counter did not count up over cut threshold.");

  property p_pg_up;
    ce_in && tick && power_good_in[0] && s_r.st[0] == ps_on
      && s_r.cnt[0] == '0 && !wr_en_in |=> s_r.cnt[0] == 12'd1;
  endproperty
  a_pg_up: assert property (p_pg_up)
    else $error("Counter did not count up above power-good level.");

  property p_trip;
    ce_in && tick && cut_sense_in[0] && s_r.st[0] == ps_on
      && s_r.cnt[0] == full_icut - 12'd1 && !wr_en_in
      && s_r.mode[1:0] != 2'h0
      |=> s_r.st[0] == ps_off && s_r.fault_oc[0] && gate_pulldown_out[0];
  endproperty
  a_trip: assert property (p_trip)
    else $error("Full count did not remove power and flag fault.");

  property p_count_down;
    ce_in && dn_tick && s_r.st[0] == ps_off && s_r.cnt[0] != '0
      |=> s_r.cnt[0] == $past(s_r.cnt[0]) - 12'd1;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("Counter did not count down on the slow tick.");

  property p_floor;
    s_r.st[0] == ps_off && s_r.cnt[0] == '0 |=> s_r.cnt[0] == '0;
  endproperty
  a_floor: assert property (p_floor)
    else $error("Counter wrapped below zero.");

  property p_refuse;
    s_r.st[0] == ps_off && s_r.cnt[0] != '0 |=> s_r.st[0] == ps_off;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("Port repowered before counter reached zero.");

  property p_auto_on;
    ce_in && s_r.st[1] == ps_off && s_r.cnt[1] == '0 && detect_good_in[1]
      && s_r.mode[3:2] == 2'h3 && !wr_en_in
      |=> s_r.st[1] == ps_start ##1 gate_pullup_out[1] || !ce_in;
  endproperty
  a_auto_on: assert property (p_auto_on)
    else $error("Auto mode did not start power-up on good detection.");

  property p_dis_idle;
    s_r.st[0] == ps_start |-> s_r.dtmr[0] == '0 && !$rose(s_r.fault_dis[0]);
  endproperty
  a_dis_idle: assert property (p_dis_idle)
    else $error("Disconnect timer ran during start-up.");

  property p_short;
    ce_in && short_trip_in[1] && s_r.st[1] != ps_off
      |=> gate_pulldown_out[1] [*2];
  endproperty
  a_short: assert property (p_short)
    else $error("Short trip did not hold the gate pull-down.");

  property p_shutdown;
    ce_in && s_r.mode[3:2] == 2'h0
      |=> s_r.st[1] == ps_off && !s_r.fault_oc[1] && !s_r.dc_en[1];
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("Shutdown mode left port bits set.");
endmodule : poe_port_overcurrent_timers

// ==== fet_sense_model.sv ====
`timescale 1ns/1ps
// Far side of each port: a MOSFET with its sense comparators. Comparators
// only report while the gate is driven; an unpowered port reads idle.
module fet_sense_model (
  // Gate drive and scenario controls
  input  wire logic [3:0] gate_on_in,
  input  wire logic [7:0] load_in,
  input  wire logic [3:0] pg_req_in,
  input  wire logic [3:0] short_req_in,
  // Comparator outputs
  output logic      [3:0] cut_out,
  output logic      [3:0] pg_out,
  output logic      [3:0] limit_out,
  output logic      [3:0] short_out,
  output logic      [3:0] under_out
);
  // Load code per port: 0 none, 1 normal, 2 over cut, 3 folded-back limit.
  // Foldback pins the current below cut, so code 3 raises only the limit.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cut_out[i]   = gate_on_in[i] && (load_in[2*i+:2] == 2'h2);
      limit_out[i] = gate_on_in[i] && (load_in[2*i+:2] == 2'h3);
      under_out[i] = gate_on_in[i] && (load_in[2*i+:2] == 2'h0);
      pg_out[i]    = gate_on_in[i] && pg_req_in[i];
      short_out[i] = gate_on_in[i] && short_req_in[i];
    end
  end
endmodule : fet_sense_model

// ==== poe_port_overcurrent_timers_tb.sv ====
`timescale 1ns/1ps
`include "poe_map.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  failures++; $display("BAD %s exp %h got %h", nm, e, g); end end
module poe_port_overcurrent_timers_tb;
  logic       sys_clk_in = 0, rst_in = 1, wr_en = 0, rd_en = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, load = 8'h00, r;
  logic [3:0] pg_req = 4'h0, sh_req = 4'h0, det = 4'h0, pu, pd;
  logic [3:0] cut, pg, lim, sh, und;
  int         failures = 0, cmp_count = 0, n;
  always #10 sys_clk_in = ~sys_clk_in;
  poe_port_overcurrent_timers #(.TICK_CYC(4), .SHORT_CYC(8))
    poe_port_overcurrent_timers_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .rd_data_out(rdata), .cut_sense_in(cut),
    .power_good_in(pg), .hard_current_limit_in(lim),
    .short_trip_in(sh), .undercurrent_in(und), .detect_good_in(det),
    .gate_pullup_out(pu), .gate_pulldown_out(pd));
  fet_sense_model fet_sense_model_inst (
    .gate_on_in(pu), .load_in(load), .pg_req_in(pg_req),
    .short_req_in(sh_req), .cut_out(cut), .pg_out(pg), .limit_out(lim),
    .short_out(sh), .under_out(und));
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_in);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge sys_clk_in);
    wr_en <= 1'b0;
  endtask : wr
  // Read data is only valid in the cycle after the strobe edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    addr <= a; rd_en <= 1'b1;
    @(posedge sys_clk_in);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a, r);
    `CHK("reg", e, r)
  endtask : rchk
  task automatic wait_pu(input int p, input logic v, input int lim_c);
    n = 0;
    while (pu[p] !== v && n < lim_c) begin cyc(1); n++; end
    if (pu[p] !== v) begin failures++; wrap_up(); end
  endtask : wait_pu
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    cyc(6);
    rst_in <= 1'b0;
    #1 `CHK("pd", 4'hf, pd)
    `CHK("pu", 4'h0, pu)
    rchk(`REG_MODE, `RST_MODE);
    rchk(`REG_DC_EN, `RST_DC_EN);
    rchk(`REG_FAULT, 8'h00);
    rchk(8'h55, 8'h00);
    wr(`REG_MODE, 8'hfd);
    wr(`REG_TIMING, 8'h24);
    rchk(`REG_TIMING, 8'h24);
    load <= 8'h05;
    wr(`REG_PWR_PB, 8'h01);
    wait_pu(0, 1'b1, 4);
    `CHK("pd0", 1'b0, pd[0])
    rchk(`REG_RUN, 8'h10);
    cyc(1400);
    rchk(`REG_STATUS, 8'h01);
    rchk(`REG_RUN, 8'h00);
    $display("startup done");
    pg_req <= 4'h1;
    cyc(40);
    pg_req <= 4'h0;
    rchk(`REG_RUN, 8'h01);
    load <= 8'h06;
    wait_pu(0, 1'b0, 1400);
    rchk(`REG_FAULT, 8'h01);
    `CHK("pd0", 1'b1, pd[0])
    rchk(`REG_FAULT, 8'h01);
    wr(`REG_PWR_PB, 8'h01);
    cyc(4);
    `CHK("pu0", 1'b0, pu[0])
    rchk(`REG_FAULT_CLR, 8'h01);
    rchk(`REG_FAULT, 8'h00);
    n = 0;
    r = 8'h01;
    // Host holds off power-on until the counter is back at zero.
    while (r[0] && n < 30000) begin rd(`REG_RUN, r); n += 2; end
    if (r[0] !== 1'b0) begin failures++; wrap_up(); end
    `CHK("slow", 1'b1, n > 18000)
    cyc(300);
    rchk(`REG_RUN, 8'h00);
    load <= 8'h05;
    wr(`REG_PWR_PB, 8'h01);
    wait_pu(0, 1'b1, 4);
    $display("overcurrent done");
    wr(`REG_PWR_PB, 8'h10);
    wait_pu(0, 1'b0, 4);
    load <= 8'h07;
    wr(`REG_PWR_PB, 8'h01);
    wait_pu(0, 1'b1, 4);
    wait_pu(0, 1'b0, 1400);
    `CHK("tstart", 1'b1, n > 1100)
    rchk(`REG_FAULT, 8'h10);
    $display("start fault done");
    load <= 8'h04;
    @(posedge sys_clk_in) det <= 4'h2;
    @(posedge sys_clk_in) det <= 4'h0;
    wait_pu(1, 1'b1, 4);
    @(posedge sys_clk_in) sh_req <= 4'h2;
    @(posedge sys_clk_in) sh_req <= 4'h0;
    #1 `CHK("short", 1'b1, pd[1])
    cyc(5);
    `CHK("hold", 1'b1, pd[1])
    wait_pu(1, 1'b1, 8);
    load <= 8'h0c;
    cyc(24);
    rd(`REG_RUN, r);
    `CHK("fold", 1'b1, r[1])
    $display("short done");
    // Port 1 draws nothing from here; disconnect may count only after start.
    load <= 8'h00;
    wr(`REG_TIMING, 8'h25);
    cyc(1200);
    rd(`REG_STATUS, r);
    `CHK("dis0", 1'b1, r[1])
    wait_pu(1, 1'b0, 3200);
    `CHK("tdis", 1'b1, n > 2500)
    rchk(`REG_STATUS, 8'h20);
    wr(`REG_STATUS, 8'h20);
    rchk(`REG_STATUS, 8'h00);
    load <= 8'h04;
    @(posedge sys_clk_in) det <= 4'h2;
    @(posedge sys_clk_in) det <= 4'h0;
    wait_pu(1, 1'b1, 4);
    $display("disconnect done");
    wr(`REG_MODE, 8'hf1);
    wait_pu(1, 1'b0, 4);
    rd(`REG_STATUS, r);
    `CHK("st1", 1'b0, r[1])
    rchk(`REG_DC_EN, 8'h0d);
    $display("shutdown done");
    wrap_up();
  end
endmodule : poe_port_overcurrent_timers_tb
